// *** core/pieb_top.sv ***
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module pieb_top (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // register port
   input wire pieb_pkg::pieb_bus_t bus,
   output logic [pieb_pkg::DATA_W-1:0] rdata,
   // event sources, one-cycle pulses
   input wire logic [pieb_pkg::DATA_W-1:0] ev_request_one,
   input wire logic [pieb_pkg::DATA_W-1:0] ev_request_two,
   // serial receive and transmit condition levels
   input wire logic serial_rx_level,
   input wire logic serial_tx_level,
   // banks held outside this block
   input wire logic [pieb_pkg::DATA_W-1:0] ext_enable_one,
   input wire logic [pieb_pkg::DATA_W-1:0] ext_request_three,
   // to the core
   output logic periph_pending,
   output logic core_irq_req,
   output logic global_irq_gate,
   output logic peripheral_irq_gate,
   // block interrupt
   output logic irq
);

   localparam int W = pieb_pkg::DATA_W;

   logic [W-1:0] periph_irq_enable_two;
   logic [W-1:0] periph_irq_enable_three;
   logic [W-1:0] periph_irq_request_one;
   logic [W-1:0] periph_irq_request_two;
   logic [W-1:0] core_irq_control;
   logic [W-1:0] irq_status;
   logic [W-1:0] irq_mask;
   logic [W-1:0] ro_level;
   logic [W-1:0] stat_set;
   logic [W-1:0] next_rdata;
   logic wr_en_two;
   logic wr_en_three;
   logic wr_req_one;
   logic wr_req_two;
   logic wr_ctrl;
   logic wr_stat;
   logic wr_mask;
   logic hit;
   logic ro_write;
   logic prev_core_irq_req;

   //------------------------------------------------------------
   // address decode
   //------------------------------------------------------------
   wire sel_en_two = bus.addr == pieb_pkg::OFS_ENABLE_TWO;
   wire sel_en_three = bus.addr == pieb_pkg::OFS_ENABLE_THREE;
   wire sel_req_one = bus.addr == pieb_pkg::OFS_REQUEST_ONE;
   wire sel_req_two = bus.addr == pieb_pkg::OFS_REQUEST_TWO;
   wire sel_ctrl = bus.addr == pieb_pkg::OFS_CORE_CONTROL;
   wire sel_stat = bus.addr == pieb_pkg::OFS_IRQ_STATUS;
   wire sel_mask = bus.addr == pieb_pkg::OFS_IRQ_MASK;

   assign hit = sel_en_two | sel_en_three | sel_req_one | sel_req_two |
      sel_ctrl | sel_stat | sel_mask;
   assign wr_en_two = bus.wr & sel_en_two;
   assign wr_en_three = bus.wr & sel_en_three;
   assign wr_req_one = bus.wr & sel_req_one;
   assign wr_req_two = bus.wr & sel_req_two;
   assign wr_ctrl = bus.wr & sel_ctrl;
   assign wr_stat = bus.wr & sel_stat;
   assign wr_mask = bus.wr & sel_mask;

   //------------------------------------------------------------
   // enable banks
   //------------------------------------------------------------
   pieb_bank_reg #(
      .WIDTH(W),
      .IMPL(pieb_pkg::BANK_TWO_IMPL),
      .WMASK(pieb_pkg::BANK_TWO_IMPL),
      .LEVEL(pieb_pkg::NO_BITS),
      .W1C(1'b0)
   ) u_enable_two (
      .clk(clk),
      .reset_n(reset_n),
      .set(pieb_pkg::NO_BITS),
      .level(pieb_pkg::NO_BITS),
      .wr_en(wr_en_two),
      .wdata(bus.wdata),
      .q(periph_irq_enable_two)
   );

   pieb_bank_reg #(
      .WIDTH(W),
      .IMPL(pieb_pkg::BANK_THREE_IMPL),
      .WMASK(pieb_pkg::BANK_THREE_IMPL),
      .LEVEL(pieb_pkg::NO_BITS),
      .W1C(1'b0)
   ) u_enable_three (
      .clk(clk),
      .reset_n(reset_n),
      .set(pieb_pkg::NO_BITS),
      .level(pieb_pkg::NO_BITS),
      .wr_en(wr_en_three),
      .wdata(bus.wdata),
      .q(periph_irq_enable_three)
   );

   //------------------------------------------------------------
   // request banks
   //------------------------------------------------------------
   assign ro_level = ({{(W-1){1'b0}}, serial_rx_level} << pieb_pkg::SERIAL_RX_BIT) |
      ({{(W-1){1'b0}}, serial_tx_level} << pieb_pkg::SERIAL_TX_BIT);

   pieb_bank_reg #(
      .WIDTH(W),
      .IMPL(pieb_pkg::ALL_BITS),
      .WMASK(pieb_pkg::REQ_ONE_WR),
      .LEVEL(pieb_pkg::REQ_ONE_RO),
      .W1C(1'b0)
   ) u_request_one (
      .clk(clk),
      .reset_n(reset_n),
      .set(ev_request_one),
      .level(ro_level),
      .wr_en(wr_req_one),
      .wdata(bus.wdata),
      .q(periph_irq_request_one)
   );

   pieb_bank_reg #(
      .WIDTH(W),
      .IMPL(pieb_pkg::BANK_TWO_IMPL),
      .WMASK(pieb_pkg::BANK_TWO_IMPL),
      .LEVEL(pieb_pkg::NO_BITS),
      .W1C(1'b0)
   ) u_request_two (
      .clk(clk),
      .reset_n(reset_n),
      .set(ev_request_two),
      .level(pieb_pkg::NO_BITS),
      .wr_en(wr_req_two),
      .wdata(bus.wdata),
      .q(periph_irq_request_two)
   );

   //------------------------------------------------------------
   // core gate bits
   //------------------------------------------------------------
   pieb_bank_reg #(
      .WIDTH(W),
      .IMPL(pieb_pkg::CTRL_IMPL),
      .WMASK(pieb_pkg::CTRL_IMPL),
      .LEVEL(pieb_pkg::NO_BITS),
      .W1C(1'b0)
   ) u_core_control (
      .clk(clk),
      .reset_n(reset_n),
      .set(pieb_pkg::NO_BITS),
      .level(pieb_pkg::NO_BITS),
      .wr_en(wr_ctrl),
      .wdata(bus.wdata),
      .q(core_irq_control)
   );

   assign global_irq_gate = core_irq_control[pieb_pkg::GLOBAL_GATE_BIT];
   assign peripheral_irq_gate = core_irq_control[pieb_pkg::PERIPH_GATE_BIT];

   //------------------------------------------------------------
   // request to the core
   //------------------------------------------------------------
   assign periph_pending = |(periph_irq_request_one & ext_enable_one) |
      |(periph_irq_request_two & periph_irq_enable_two) |
      |(ext_request_three & periph_irq_enable_three);
   assign core_irq_req = periph_pending & peripheral_irq_gate &
      global_irq_gate;

   //------------------------------------------------------------
   // block status and mask
   //------------------------------------------------------------
   assign ro_write = wr_req_one &
      |((bus.wdata ^ periph_irq_request_one) & pieb_pkg::REQ_ONE_RO);
   assign stat_set = ({{(W-1){1'b0}}, core_irq_req & ~prev_core_irq_req}
      << pieb_pkg::STAT_IRQ_RISE_BIT) |
      ({{(W-1){1'b0}}, ro_write} << pieb_pkg::STAT_RO_WRITE_BIT) |
      ({{(W-1){1'b0}}, (bus.wr | bus.rd) & ~hit} << pieb_pkg::STAT_UNMAPPED_BIT);

   pieb_bank_reg #(
      .WIDTH(W),
      .IMPL(pieb_pkg::STAT_IMPL),
      .WMASK(pieb_pkg::STAT_IMPL),
      .LEVEL(pieb_pkg::NO_BITS),
      .W1C(1'b1)
   ) u_irq_status (
      .clk(clk),
      .reset_n(reset_n),
      .set(stat_set),
      .level(pieb_pkg::NO_BITS),
      .wr_en(wr_stat),
      .wdata(bus.wdata),
      .q(irq_status)
   );

   pieb_bank_reg #(
      .WIDTH(W),
      .IMPL(pieb_pkg::STAT_IMPL),
      .WMASK(pieb_pkg::STAT_IMPL),
      .LEVEL(pieb_pkg::NO_BITS),
      .W1C(1'b0)
   ) u_irq_mask (
      .clk(clk),
      .reset_n(reset_n),
      .set(pieb_pkg::NO_BITS),
      .level(pieb_pkg::NO_BITS),
      .wr_en(wr_mask),
      .wdata(bus.wdata),
      .q(irq_mask)
   );

   assign irq = |(irq_status & irq_mask);

   //------------------------------------------------------------
   // read data, one cycle after the strobe
   //------------------------------------------------------------
   assign next_rdata = !bus.rd ? pieb_pkg::RESET_VALUE :
      sel_en_two ? periph_irq_enable_two :
      sel_en_three ? periph_irq_enable_three :
      sel_req_one ? periph_irq_request_one :
      sel_req_two ? periph_irq_request_two :
      sel_ctrl ? core_irq_control :
      sel_stat ? irq_status :
      sel_mask ? irq_mask : pieb_pkg::RESET_VALUE;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rdata <= pieb_pkg::RESET_VALUE;
         prev_core_irq_req <= 1'b0;
      end else begin
         rdata <= next_rdata;
         prev_core_irq_req <= core_irq_req;
      end
   end

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   localparam logic [W-1:0] WR_EV_MASK = pieb_pkg::REQ_ONE_WR;

   property p_flag_sets;
      @(posedge clk) disable iff (!reset_n)
      (ev_request_one & WR_EV_MASK) != 8'h00 |=>
         (periph_irq_request_one & $past(ev_request_one) & WR_EV_MASK) ==
         ($past(ev_request_one) & WR_EV_MASK);
   endproperty
   a_flag_sets: assert property (p_flag_sets)
      else $error("request flag missed its event");

   property p_set_beats_clear;
      @(posedge clk) disable iff (!reset_n)
      (wr_req_two && bus.wdata == 8'h00 && ev_request_two != 8'h00) |=>
         periph_irq_request_two == ($past(ev_request_two) & pieb_pkg::BANK_TWO_IMPL);
   endproperty
   a_set_beats_clear: assert property (p_set_beats_clear)
      else $error("event lost against a software clear");

   property p_ro_follows_level;
      @(posedge clk) disable iff (!reset_n)
      wr_req_one |=> (periph_irq_request_one & pieb_pkg::REQ_ONE_RO) ==
         $past(ro_level);
   endproperty
   a_ro_follows_level: assert property (p_ro_follows_level)
      else $error("read-only flag took a write");

   property p_holes_zero;
      @(posedge clk) disable iff (!reset_n)
      !periph_irq_enable_two[pieb_pkg::BANK_TWO_HOLE_BIT] &&
      !periph_irq_request_two[pieb_pkg::BANK_TWO_HOLE_BIT] &&
      !periph_irq_enable_three[pieb_pkg::BANK_THREE_HOLE_BIT];
   endproperty
   a_holes_zero: assert property (p_holes_zero)
      else $error("unimplemented bit reads one");

   property p_reset_clears;
      @(posedge clk) !reset_n |=> periph_irq_enable_two == 8'h00 &&
         periph_irq_enable_three == 8'h00 && periph_irq_request_two == 8'h00 &&
         (periph_irq_request_one & WR_EV_MASK) == 8'h00 && !core_irq_req;
   endproperty
   a_reset_clears: assert property (p_reset_clears)
      else $error("bank not cleared by reset");

   property p_periph_gate;
      @(posedge clk) disable iff (!reset_n)
      !peripheral_irq_gate |-> !core_irq_req;
   endproperty
   a_periph_gate: assert property (p_periph_gate)
      else $error("request passed with peripheral gate off");

   property p_global_gate;
      @(posedge clk) disable iff (!reset_n)
      !global_irq_gate |-> !core_irq_req;
   endproperty
   a_global_gate: assert property (p_global_gate)
      else $error("request passed with global gate off");

   property p_enable_blocks;
      @(posedge clk) disable iff (!reset_n)
      (ext_enable_one == 8'h00 && periph_irq_enable_two == 8'h00 &&
       periph_irq_enable_three == 8'h00) |-> !core_irq_req;
   endproperty
   a_enable_blocks: assert property (p_enable_blocks)
      else $error("request passed with all enables off");

   property p_read_back;
      @(posedge clk) disable iff (!reset_n)
      (bus.rd && sel_req_two) |=> rdata == $past(periph_irq_request_two);
   endproperty
   a_read_back: assert property (p_read_back)
      else $error("request bank read wrong");

   property p_request_cause;
      @(posedge clk) disable iff (!reset_n)
      core_irq_req |-> periph_pending && global_irq_gate && peripheral_irq_gate;
   endproperty
   a_request_cause: assert property (p_request_cause)
      else $error("request without a cause");

   property p_cv_request;
      @(posedge clk) disable iff (!reset_n)
      $rose(core_irq_req);
   endproperty
   c_cv_request: cover property (p_cv_request);

   property p_cv_collide;
      @(posedge clk) disable iff (!reset_n)
      wr_req_two && ev_request_two != 8'h00;
   endproperty
   c_cv_collide: cover property (p_cv_collide);

   property p_cv_irq;
      @(posedge clk) disable iff (!reset_n)
      $rose(irq);
   endproperty
   c_cv_irq: cover property (p_cv_irq);

endmodule : pieb_top

// *** core/pieb_pkg.sv ***
//------------------------------------------------------------
// peripheral interrupt enable and request banks
//------------------------------------------------------------
package pieb_pkg;

   localparam int DATA_W = 8;
   localparam int ADDR_W = 4;

   //------------------------------------------------------------
   // register offsets
   //------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_ENABLE_TWO = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_ENABLE_THREE = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_REQUEST_ONE = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_REQUEST_TWO = 4'h3;
   localparam logic [ADDR_W-1:0] OFS_CORE_CONTROL = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'h5;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h6;

   //------------------------------------------------------------
   // bit positions
   //------------------------------------------------------------
   localparam int OSC_FAIL_BIT = 7;
   localparam int COMPARATOR_TWO_BIT = 6;
   localparam int COMPARATOR_ONE_BIT = 5;
   localparam int BANK_TWO_HOLE_BIT = 4;
   localparam int BUS_COLLISION_BIT = 3;
   localparam int BANK_THREE_HOLE_BIT = 7;
   localparam int NUMERIC_OSC_BIT = 6;
   localparam int ZERO_CROSS_BIT = 4;
   localparam int SERIAL_RX_BIT = 5;
   localparam int SERIAL_TX_BIT = 4;
   localparam int TIMER_ONE_GATE_BIT = 7;
   localparam int GLOBAL_GATE_BIT = 7;
   localparam int PERIPH_GATE_BIT = 6;
   localparam int STAT_IRQ_RISE_BIT = 0;
   localparam int STAT_RO_WRITE_BIT = 1;
   localparam int STAT_UNMAPPED_BIT = 2;

   //------------------------------------------------------------
   // implemented, writable and hardware-owned masks
   //------------------------------------------------------------
   localparam logic [DATA_W-1:0] ALL_BITS = 8'hff;
   localparam logic [DATA_W-1:0] NO_BITS = 8'h00;
   localparam logic [DATA_W-1:0] BANK_TWO_IMPL = ALL_BITS & ~(8'h01 << BANK_TWO_HOLE_BIT);
   localparam logic [DATA_W-1:0] BANK_THREE_IMPL = ALL_BITS & ~(8'h01 << BANK_THREE_HOLE_BIT);
   localparam logic [DATA_W-1:0] REQ_ONE_RO =
      (8'h01 << SERIAL_RX_BIT) | (8'h01 << SERIAL_TX_BIT);
   localparam logic [DATA_W-1:0] REQ_ONE_WR = ALL_BITS & ~REQ_ONE_RO;
   localparam logic [DATA_W-1:0] CTRL_IMPL =
      (8'h01 << GLOBAL_GATE_BIT) | (8'h01 << PERIPH_GATE_BIT);
   localparam logic [DATA_W-1:0] STAT_IMPL = 8'h07;
   localparam logic [DATA_W-1:0] RESET_VALUE = 8'h00;

   //------------------------------------------------------------
   // register port request
   //------------------------------------------------------------
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } pieb_bus_t;

endpackage : pieb_pkg

// *** core/pieb_bank_reg.sv ***
`timescale 1ns/1ps
// one 8-bit bank: per bit either unimplemented, hardware level, or
// event-set with software write (plain or write-one-to-clear)
module pieb_bank_reg #(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] IMPL = '1,
   parameter logic [WIDTH-1:0] WMASK = '1,
   parameter logic [WIDTH-1:0] LEVEL = '0,
   parameter bit W1C = 1'b0
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // hardware side
   input wire logic [WIDTH-1:0] set,
   input wire logic [WIDTH-1:0] level,
   // software side
   input wire logic wr_en,
   input wire logic [WIDTH-1:0] wdata,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] wr_val;
   logic [WIDTH-1:0] next_q;

   //------------------------------------------------------------
   // per-bit next value
   //------------------------------------------------------------
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      assign wr_val[i] = W1C ? (q[i] & ~wdata[i]) : wdata[i];
      // set term ORed last so an event beats a clear in the same cycle
      assign next_q[i] = !IMPL[i] ? 1'b0 :
         LEVEL[i] ? level[i] :
         (set[i] | ((wr_en && WMASK[i]) ? wr_val[i] : q[i]));
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

endmodule : pieb_bank_reg

// *** tb/pieb_partner.sv ***
`timescale 1ns/1ps
// event sources and the banks held beside the block
module pieb_partner (
   // clock
   input wire logic clk,
   // event pulses and levels
   output logic [7:0] ev_one,
   output logic [7:0] ev_two,
   output logic rx,
   output logic tx,
   output logic [7:0] en_one,
   output logic [7:0] req_three
);
   initial begin
      ev_one = 8'h00;
      ev_two = 8'h00;
      rx = 1'b0;
      tx = 1'b0;
      en_one = 8'h00;
      req_three = 8'h00;
   end

   // events last one cycle; the third request bank is a level
   task automatic raise(input int k, input logic [7:0] bits);
      @(posedge clk);
      if (k == 0) ev_one <= bits;
      else if (k == 1) ev_two <= bits;
      else req_three <= bits;
      @(posedge clk);
      ev_one <= 8'h00;
      ev_two <= 8'h00;
   endtask : raise

   task automatic levels(input logic [7:0] en, input logic r, input logic t);
      @(posedge clk);
      en_one <= en;
      rx <= r;
      tx <= t;
   endtask : levels
endmodule : pieb_partner

// *** tb/tb_pieb_top.sv ***
`timescale 1ns/1ps
module tb_pieb_top;
   logic clk;
   logic reset_n;
   pieb_pkg::pieb_bus_t bus;
   logic [7:0] rdata, ev_one, ev_two, en_one, req_three;
   logic rx, tx, pend, core, gg, pg, irq;
   int fails, cmp_count, k, c;
   logic [7:0] tbl [4] = '{8'hef, 8'h7f, 8'hcf, 8'hef};

   pieb_top pieb_top_i (.clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
      .ev_request_one(ev_one), .ev_request_two(ev_two), .serial_rx_level(rx),
      .serial_tx_level(tx), .ext_enable_one(en_one), .ext_request_three(req_three),
      .periph_pending(pend), .core_irq_req(core), .global_irq_gate(gg),
      .peripheral_irq_gate(pg), .irq(irq));
   pieb_partner pieb_partner_i (.clk(clk), .ev_one(ev_one), .ev_two(ev_two), .rx(rx),
      .tx(tx), .en_one(en_one), .req_three(req_three));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   //------------------------------------------------------------
   // checks and register access
   //------------------------------------------------------------
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask : chk

   task automatic see(input string n, ref logic g, input logic e);
      @(negedge clk);
      chk(n, {7'h0, e}, {7'h0, g});
   endtask : see

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge clk);
      bus.rd <= 1'b0;
      @(negedge clk);
      chk($sformatf("reg%h", a), e, rdata);
   endtask : rd

   // one enable bit at a time: other sources blocked, own source passes unless its bit is unimplemented or read-only
   task automatic map_test(input int b);
      logic [7:0] m;
      logic [7:0] hole;
      int i;
      hole = (b == 0) ? 8'h30 : (b == 1) ? 8'h10 : 8'h80;
      for (i = 0; i < 8; i++) begin
         m = 8'h01 << i;
         if (b == 0) pieb_partner_i.levels(m, 1'b0, 1'b0);
         else wr((b == 1) ? 4'h0 : 4'h1, m);
         pieb_partner_i.raise(b, ~m & ~hole);
         see("core_irq_req", core, 1'b0);
         pieb_partner_i.raise(b, m);
         see("core_irq_req", core, ~|(m & hole));
         if (b == 2) pieb_partner_i.raise(2, 8'h00);
         else wr((b == 0) ? 4'h2 : 4'h3, 8'h00);
      end
      if (b == 0) pieb_partner_i.levels(8'h00, 1'b0, 1'b0);
      else wr((b == 1) ? 4'h0 : 4'h1, 8'h00);
   endtask : map_test

   task automatic final_report;
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : final_report

   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      final_report();
   end

   //------------------------------------------------------------
   // tests
   //------------------------------------------------------------
   initial begin
      bus = '0;
      reset_n = 1'b0;
      fails = 0;
      cmp_count = 0;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      for (k = 0; k < 7; k++) rd(k[3:0], 8'h00);
      $display("test reset values done");
      for (k = 0; k < 4; k++) begin
         wr(k[3:0], 8'hff);
         rd(k[3:0], tbl[k]);
         wr(k[3:0], 8'h00);
         rd(k[3:0], 8'h00);
      end
      rd(4'h5, 8'h02);
      wr(4'h5, 8'hff);
      rd(4'h5, 8'h00);
      for (k = 0; k < 4; k++) begin
         pieb_partner_i.levels(8'h00, k[1], k[0]);
         rd(4'h2, {2'b00, k[1:0], 4'h0});
      end
      pieb_partner_i.levels(8'h00, 1'b0, 1'b0);
      $display("test access done");
      pieb_partner_i.raise(0, 8'hff);
      pieb_partner_i.raise(1, 8'hff);
      rd(4'h2, 8'hcf);
      rd(4'h3, 8'hef);
      see("periph_pending", pend, 1'b0);
      wr(4'h4, 8'hc0);
      rd(4'h4, 8'hc0);
      wr(4'h2, 8'h00);
      wr(4'h3, 8'h00);
      see("core_irq_req", core, 1'b0);
      for (k = 0; k < 3; k++) map_test(k);
      $display("test mapping done");
      wr(4'h0, 8'h80);
      pieb_partner_i.raise(1, 8'h80);
      for (c = 0; c < 4; c++) begin
         wr(4'h4, {c[1:0], 6'h00});
         see("core_irq_req", core, c == 3);
         chk("gates", {6'h00, c[1:0]}, {6'h00, gg, pg});
         chk("periph_pending", 8'h01, {7'h0, pend});
      end
      wr(4'h0, 8'h00);
      see("core_irq_req", core, 1'b0);
      rd(4'h3, 8'h80);
      fork
         wr(4'h3, 8'h00);
         pieb_partner_i.raise(1, 8'h01);
      join
      rd(4'h3, 8'h01);
      wr(4'h3, 8'h00);
      $display("test gates done");
      wr(4'h5, 8'hff);
      rd(4'h5, 8'h00);
      wr(4'h6, 8'h07);
      rd(4'h6, 8'h07);
      rd(4'h9, 8'h00);
      rd(4'h5, 8'h04);
      see("irq", irq, 1'b1);
      wr(4'h5, 8'h04);
      see("irq", irq, 1'b0);
      wr(4'h0, 8'h01);
      pieb_partner_i.raise(1, 8'h01);
      rd(4'h5, 8'h01);
      see("irq", irq, 1'b1);
      wr(4'h6, 8'h00);
      see("irq", irq, 1'b0);
      wr(4'h6, 8'h01);
      see("irq", irq, 1'b1);
      wr(4'h3, 8'h00);
      wr(4'h5, 8'h01);
      see("irq", irq, 1'b0);
      $display("test interrupt done");
      wr(4'h0, 8'hff);
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      rd(4'h0, 8'h00);
      rd(4'h6, 8'h00);
      $display("test second reset done");
      final_report();
   end
endmodule : tb_pieb_top
